// file: ctg_defs.vh
// Constants for the camera exposure timing generator
`ifndef CTG_DEFS_VH
`define CTG_DEFS_VH
// Clock rate and time base: one tick of the duration counters
`define CTG_CLK_HZ 10000000
`define CTG_TICK_NS 1000
`define CTG_TICK_CYCLES ((`CTG_TICK_NS * (`CTG_CLK_HZ / 1000000)) / 1000)
// Trigger mode encodings
`define CTG_MODE_CONTINUOUS 2'h0
`define CTG_MODE_SINGLE_ON_TRIGGER 2'h1
`define CTG_MODE_SINGLE_ON_ENCODER 2'h2
`define CTG_MODE_INVALID 2'h3
// Route mask bit positions
`define CTG_ROUTE_CAM_LO 0
`define CTG_ROUTE_GENERAL_OUT_0 4
`define CTG_ROUTE_TO_TRIGGER_IN 8
`define CTG_ROUTE_TO_ENCODER_A 9
`define CTG_ROUTE_TO_ENCODER_B 10
`define CTG_ROUTE_W 11
`define CTG_ROUTE_GRP_W 4
// State codes
`define CTG_ST_IDLE 2'h0
`define CTG_ST_ACTIVE 2'h1
`define CTG_ST_REST 2'h2
`endif

// file: ctg_camera_timing_gen.v
// Camera exposure timing generator: one pulse waveform routed to many destinations
// Overview of operation
// - Continuous mode repeats the waveform every period without any event.
// - Single-on-trigger mode runs one cycle per trigger input event that arrives while idle.
// - Single-on-encoder mode runs one cycle per encoder input event that arrives while idle.
// - Event source is the currently selected trigger or encoder input.
// - One setting selects whether the active level is high or low.
// - Exposure duration is programmable in fine fractional-millisecond ticks.
// - Line/frame interval is programmed as a period, not a frequency.
// - Output route mask is a bit set; any combination allowed.
// - Identical waveform appears at once on every enabled destination.
// - Destinations include four camera lines and four general outputs.
// - Internal trigger destination feeds the board's trigger input path.
// - Encoder destinations feed encoder A input, and encoder B input.
// - Generator runs on its own timing, independent of acquisition logic.
`include "ctg_defs.vh"
`default_nettype none
module ctg_camera_timing_gen #(
  parameter CNT_W = 24
) (
  input wire MCLK_I,
  input wire RESET_N_I,
  input wire [CNT_W-1:0] EXPOSURE_DURATION_I,
  input wire [CNT_W-1:0] LINE_FRAME_INTERVAL_I,
  input wire [1:0] TRIGGER_MODE_SELECT_I,
  input wire ACTIVE_LEVEL_HIGH_I,
  input wire [`CTG_ROUTE_W-1:0] OUTPUT_ROUTE_MASK_I,
  input wire TRIGGER_EVENT_I,
  input wire ENCODER_EVENT_I,
  output reg [3:0] CAMERA_CONTROL_O,
  output reg [3:0] GENERAL_OUT_O,
  output reg ROUTE_TO_TRIGGER_IN_O,
  output reg ROUTE_TO_ENCODER_A_O,
  output reg ROUTE_TO_ENCODER_B_O,
  output reg CONFIG_ERROR_O,
  output reg BUSY_O
);

  localparam [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam integer TICK_LAST_INT = `CTG_TICK_CYCLES - 1;
  // Cut on purpose: the prescaler never needs more than 16 bits
  localparam [15:0] TICK_LAST = TICK_LAST_INT[15:0];

  // Time base
  reg [15:0] prescale;
  reg tick;

  // Cycle sequencer
  reg [1:0] state;
  reg [1:0] next_state;
  reg [CNT_W-1:0] count;
  reg [CNT_W-1:0] next_count;
  reg wave_active;
  reg next_wave_active;

  // Event edge detect
  reg trig_prev;
  reg enc_prev;
  wire trig_rise;
  wire enc_rise;
  reg event_hit;

  // Settings check and output shaping
  wire exp_too_long;
  wire exp_zero;
  wire mode_unknown;
  wire cfg_bad;
  wire wave_level;
  wire [`CTG_ROUTE_GRP_W-1:0] cam_sel;
  wire [`CTG_ROUTE_GRP_W-1:0] gen_sel;

  // Free-running time base, shared by nothing else in the device
  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      prescale <= 16'h0000;
      tick <= 1'b0;
    end else if (prescale == TICK_LAST) begin
      prescale <= 16'h0000;
      tick <= 1'b1;
    end else begin
      prescale <= prescale + 16'h0001;
      tick <= 1'b0;
    end
  end

  assign trig_rise = TRIGGER_EVENT_I & ~trig_prev;
  assign enc_rise = ENCODER_EVENT_I & ~enc_prev;

  // Bad settings hold the output idle rather than produce a malformed pulse
  assign exp_too_long = (EXPOSURE_DURATION_I > LINE_FRAME_INTERVAL_I);
  assign exp_zero = (EXPOSURE_DURATION_I == {CNT_W{1'b0}});
  assign mode_unknown = (TRIGGER_MODE_SELECT_I == `CTG_MODE_INVALID);
  // A cycle already running finishes; only new starts are blocked
  assign cfg_bad = exp_too_long | exp_zero | mode_unknown;

  always @* begin
    case (TRIGGER_MODE_SELECT_I)
      `CTG_MODE_CONTINUOUS: event_hit = 1'b1;
      `CTG_MODE_SINGLE_ON_TRIGGER: event_hit = trig_rise;
      `CTG_MODE_SINGLE_ON_ENCODER: event_hit = enc_rise;
      default: event_hit = 1'b0;
    endcase
  end

  always @* begin
    next_state = state;
    next_count = count;
    next_wave_active = wave_active;
    case (state)
      `CTG_ST_IDLE: begin
        // Events only start a cycle from idle
        if (event_hit && !cfg_bad) begin
          next_state = `CTG_ST_ACTIVE;
          next_count = ONE;
          next_wave_active = 1'b1;
        end
      end
      `CTG_ST_ACTIVE: begin
        if (tick) begin
          if (count >= EXPOSURE_DURATION_I) begin
            next_wave_active = 1'b0;
            if (count >= LINE_FRAME_INTERVAL_I) begin
              next_state = `CTG_ST_IDLE;
            end else begin
              next_state = `CTG_ST_REST;
              next_count = count + ONE;
            end
          end else begin
            next_count = count + ONE;
          end
        end
      end
      `CTG_ST_REST: begin
        if (tick) begin
          if (count >= LINE_FRAME_INTERVAL_I) begin
            next_state = `CTG_ST_IDLE;
          end else begin
            next_count = count + ONE;
          end
        end
      end
      default: begin
        next_state = `CTG_ST_IDLE;
        next_wave_active = 1'b0;
      end
    endcase
  end

  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state <= `CTG_ST_IDLE;
      count <= {CNT_W{1'b0}};
      wave_active <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      wave_active <= next_wave_active;
    end
  end

  // Low at reset matches the idle level of both event pins, so no false edge follows reset
  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      trig_prev <= 1'b0;
      enc_prev <= 1'b0;
    end else begin
      trig_prev <= TRIGGER_EVENT_I;
      enc_prev <= ENCODER_EVENT_I;
    end
  end

  assign wave_level = ACTIVE_LEVEL_HIGH_I ? wave_active : ~wave_active;

  assign cam_sel = OUTPUT_ROUTE_MASK_I[`CTG_ROUTE_CAM_LO+`CTG_ROUTE_GRP_W-1:`CTG_ROUTE_CAM_LO];
  assign gen_sel = OUTPUT_ROUTE_MASK_I[`CTG_ROUTE_GENERAL_OUT_0+`CTG_ROUTE_GRP_W-1:`CTG_ROUTE_GENERAL_OUT_0];

  // Unselected destinations rest low; the same level feeds all selected ones
  // All pins register one level, so every selected pin switches on the same edge
  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      CAMERA_CONTROL_O <= 4'h0;
      GENERAL_OUT_O <= 4'h0;
    end else begin
      CAMERA_CONTROL_O <= cam_sel & {`CTG_ROUTE_GRP_W{wave_level}};
      GENERAL_OUT_O <= gen_sel & {`CTG_ROUTE_GRP_W{wave_level}};
    end
  end

  // Internal destinations loop the waveform back into the board's own inputs
  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ROUTE_TO_TRIGGER_IN_O <= 1'b0;
      ROUTE_TO_ENCODER_A_O <= 1'b0;
      ROUTE_TO_ENCODER_B_O <= 1'b0;
    end else begin
      ROUTE_TO_TRIGGER_IN_O <= OUTPUT_ROUTE_MASK_I[`CTG_ROUTE_TO_TRIGGER_IN] & wave_level;
      ROUTE_TO_ENCODER_A_O <= OUTPUT_ROUTE_MASK_I[`CTG_ROUTE_TO_ENCODER_A] & wave_level;
      ROUTE_TO_ENCODER_B_O <= OUTPUT_ROUTE_MASK_I[`CTG_ROUTE_TO_ENCODER_B] & wave_level;
    end
  end

  // Status flags; the error flag tracks the settings even while a cycle finishes
  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      CONFIG_ERROR_O <= 1'b0;
      BUSY_O <= 1'b0;
    end else begin
      CONFIG_ERROR_O <= cfg_bad;
      BUSY_O <= (state != `CTG_ST_IDLE);
    end
  end

endmodule // ctg_camera_timing_gen
`default_nettype wire

// file: ctg_port_chk_assertions.sv
// Port checker for the camera timing generator
`include "ctg_defs.vh"
`default_nettype none
module ctg_port_chk #(parameter CNT_W = 24) (
  input wire logic MCLK_I,
  input wire logic RESET_N_I,
  input wire logic ACTIVE_LEVEL_HIGH_I,
  input wire logic BUSY_O,
  input wire logic TRIGGER_EVENT_I,
  input wire logic ENCODER_EVENT_I,
  input wire logic CONFIG_ERROR_O,
  input wire logic ROUTE_TO_TRIGGER_IN_O,
  input wire logic ROUTE_TO_ENCODER_A_O,
  input wire logic ROUTE_TO_ENCODER_B_O,
  input wire logic [1:0] TRIGGER_MODE_SELECT_I,
  input wire logic [3:0] CAMERA_CONTROL_O,
  input wire logic [3:0] GENERAL_OUT_O,
  input wire logic [`CTG_ROUTE_W-1:0] OUTPUT_ROUTE_MASK_I,
  input wire logic [CNT_W-1:0] EXPOSURE_DURATION_I,
  input wire logic [CNT_W-1:0] LINE_FRAME_INTERVAL_I
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);
  wire bad = EXPOSURE_DURATION_I > LINE_FRAME_INTERVAL_I || ~|EXPOSURE_DURATION_I || &TRIGGER_MODE_SELECT_I;
  wire [1:0] md = TRIGGER_MODE_SELECT_I;
  // Three idle samples so the registered output has caught up with busy
  sequence s_rest; (!BUSY_O && OUTPUT_ROUTE_MASK_I[0] && $stable(ACTIVE_LEVEL_HIGH_I))[*3]; endsequence
  property p_off; !OUTPUT_ROUTE_MASK_I[0] |=> !CAMERA_CONTROL_O[0]; endproperty
  a_off: assert property (p_off) else $error("off line driven");
  property p_same; &OUTPUT_ROUTE_MASK_I |=> {CAMERA_CONTROL_O, GENERAL_OUT_O, ROUTE_TO_TRIGGER_IN_O,
    ROUTE_TO_ENCODER_A_O, ROUTE_TO_ENCODER_B_O} == {11{CAMERA_CONTROL_O[0]}}; endproperty
  a_same: assert property (p_same) else $error("outputs differ");
  property p_rest; s_rest |-> CAMERA_CONTROL_O[0] == !ACTIVE_LEVEL_HIGH_I; endproperty
  a_rest: assert property (p_rest) else $error("idle level wrong");
  property p_err; 1'b1 |=> CONFIG_ERROR_O == $past(bad); endproperty
  a_err: assert property (p_err) else $error("error flag wrong");
  property p_block; bad[*3] |-> !$rose(BUSY_O); endproperty
  a_block: assert property (p_block) else $error("bad setup started");
  property p_free; $fell(BUSY_O) && md == `CTG_MODE_CONTINUOUS && !bad |-> ##[1:3] BUSY_O; endproperty
  a_free: assert property (p_free) else $error("no restart");
  property p_trig; $rose(BUSY_O) && md == `CTG_MODE_SINGLE_ON_TRIGGER |-> $past(TRIGGER_EVENT_I) ||
    $past(TRIGGER_EVENT_I, 2) || $past(TRIGGER_EVENT_I, 3); endproperty
  a_trig: assert property (p_trig) else $error("start without trigger");
  property p_enc; $rose(BUSY_O) && md == `CTG_MODE_SINGLE_ON_ENCODER |-> $past(ENCODER_EVENT_I) ||
    $past(ENCODER_EVENT_I, 2) || $past(ENCODER_EVENT_I, 3); endproperty
  a_enc: assert property (p_enc) else $error("start without encoder");
endmodule // ctg_port_chk
bind ctg_camera_timing_gen ctg_port_chk #(.CNT_W(CNT_W)) u_chk (.*);
`default_nettype wire

// file: ctg_event_src.sv
// Trigger and encoder sources at the generator's far side
`default_nettype none
module ctg_event_src (
  input wire logic clk_i,
  input wire logic fire_t_i,
  input wire logic fire_e_i,
  output logic trig_o,
  output logic enc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] t = 3'h0, e = 3'h0;
  // Four-cycle pulses: long enough for the edge detect, gone before a cycle ends
  always @(posedge clk_i) t <= fire_t_i ? 3'h4 : t - {2'h0, |t};
  always @(posedge clk_i) e <= fire_e_i ? 3'h4 : e - {2'h0, |e};
  assign trig_o = |t;
  assign enc_o = |e;
endmodule // ctg_event_src
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the camera timing generator
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic MCLK_I = 1'b0, RESET_N_I = 1'b0, ACTIVE_LEVEL_HIGH_I = 1'b1, go_t = 1'b0, go_e = 1'b0, got;
  logic [23:0] EXPOSURE_DURATION_I = 24'h000002, LINE_FRAME_INTERVAL_I = 24'h000004, ex[3] = '{24'h5, 24'h0, 24'h2};
  logic [1:0] TRIGGER_MODE_SELECT_I = 2'h0, md[3] = '{2'h2, 2'h2, 2'h3};
  logic [10:0] OUTPUT_ROUTE_MASK_I = 11'h7FF;
  logic TRIGGER_EVENT_I, ENCODER_EVENT_I, ROUTE_TO_TRIGGER_IN_O, ROUTE_TO_ENCODER_A_O, ROUTE_TO_ENCODER_B_O;
  logic CONFIG_ERROR_O, BUSY_O;
  logic [3:0] CAMERA_CONTROL_O, GENERAL_OUT_O;
  int error_cnt = 0, samples_checked = 0, act, len;
  initial forever #50 MCLK_I = ~MCLK_I;
  ctg_camera_timing_gen #(.CNT_W(24)) DUT (.*);
  ctg_event_src src (.clk_i(MCLK_I), .fire_t_i(go_t), .fire_e_i(go_e), .trig_o(TRIGGER_EVENT_I), .enc_o(ENCODER_EVENT_I));
  task automatic tick(input int n); repeat (n) @(posedge MCLK_I); #1; endtask
  task automatic fire(input logic t, e); go_t = t; go_e = e; tick(1); go_t = 1'b0; go_e = 1'b0; endtask
  task automatic check(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Waits a bounded time for a cycle, then measures active and busy lengths
  task automatic run(input int lim);
    act = 0;
    len = 0;
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      tick(1);
      got = BUSY_O === 1'b1;
    end
    while (got && BUSY_O === 1'b1 && len < 99) begin
      len++;
      act += int'(CAMERA_CONTROL_O[0] === ACTIVE_LEVEL_HIGH_I);
      tick(1);
    end
    if (got) check("cycle end", len < 99, 1);
  endtask
  initial begin
    tick(3);
    RESET_N_I = 1'b1;
    run(60);
    run(60);
    check("free run", got, 1);
    check("exposure", act > 9 && act < 22, 1);
    check("period", len > 29 && len < 43, 1);
    tick(5);
    ACTIVE_LEVEL_HIGH_I = 1'b0;
    TRIGGER_MODE_SELECT_I = 2'h1;
    tick(50);
    fire(0, 1);
    run(30);
    check("wrong source", got, 0);
    fire(1, 0);
    run(9);
    check("low exposure", act > 9 && act < 22, 1);
    fire(1, 0);
    tick(15);
    fire(1, 0);
    tick(40);
    run(20);
    check("retrigger", got, 0);
    TRIGGER_MODE_SELECT_I = 2'h2;
    fire(0, 1);
    run(9);
    check("encoder shot", got, 1);
    for (int k = 0; k < 3; k++) begin
      EXPOSURE_DURATION_I = ex[k];
      TRIGGER_MODE_SELECT_I = md[k];
      fire(1, 1);
      run(20);
      check("config error", {CONFIG_ERROR_O, got}, 2'h2);
    end
    EXPOSURE_DURATION_I = 24'h000004;
    TRIGGER_MODE_SELECT_I = 2'h2;
    for (int k = 0; k < 11; k++) begin
      OUTPUT_ROUTE_MASK_I = 11'h001 << k;
      tick(3);
      check("route", {ROUTE_TO_ENCODER_B_O, ROUTE_TO_ENCODER_A_O, ROUTE_TO_TRIGGER_IN_O, GENERAL_OUT_O,
        CAMERA_CONTROL_O, CONFIG_ERROR_O}, {OUTPUT_ROUTE_MASK_I, 1'b0});
    end
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
